/* include/dapm_regs.vh */
// Constants of the digital audio port mapper: register map, field
// positions, reset values and channel-status codes.
// Assumes inclusion by bare name from the design files.
`ifndef DAPM_REGS_VH
`define DAPM_REGS_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define DAPM_CTRL_OFS 4'h0
`define DAPM_STAT_OFS 4'h4
`define DAPM_DROP_OFS 4'h8
`define DAPM_CTRL_RST 32'h0000_0002

// ----------------------------------------
// Control fields
// ----------------------------------------
`define DAPM_C_RATE_LSB 0
`define DAPM_C_MASTER 3
`define DAPM_C_PREF_LSB 4
`define DAPM_C_OPT4_SPDIF 7
`define DAPM_C_PRO 8
`define DAPM_C_NONAUDIO 9
`define DAPM_C_WC_BASE 10
`define DAPM_C_WIDTH 11

// ----------------------------------------
// Sample rate codes and speeds
// ----------------------------------------
`define DAPM_R32 3'h0
`define DAPM_R44 3'h1
`define DAPM_R48 3'h2
`define DAPM_R64 3'h3
`define DAPM_R88 3'h4
`define DAPM_R96 3'h5
`define DAPM_R176 3'h6
`define DAPM_R192 3'h7
`define DAPM_SPD_SINGLE 2'h0
`define DAPM_SPD_DOUBLE 2'h1
`define DAPM_SPD_QUAD 2'h2

// ----------------------------------------
// Channel-status fields (byte values in block)
// ----------------------------------------
`define DAPM_CS_BITS 8'hc0
`define DAPM_CS_PRO_B0 8'h01
`define DAPM_CS_PRO_EMPH_NONE 8'h04
`define DAPM_CS_PRO_2CH 8'h08
`define DAPM_CS_PRO_AUX24 8'h01
`define DAPM_CS_CON_COPY 8'h04
`define DAPM_CS_NONAUDIO 8'h02

// ----------------------------------------
// Port geometry and buffering
// ----------------------------------------
`define DAPM_NPORT 3'h4
`define DAPM_NSRC 6
`define DAPM_FIFO_W 31
`define DAPM_FIFO_D 16
`define DAPM_FIFO_AW 4

`endif

/* hdl/dapm_top.v */
// Digital audio port mapper: four eight-slot optical ports, channel-status
// generation for AES and SPDIF outputs, sync selection, word clock limit.
// Assumes one 40 MHz clock, an AXI4-Lite master and slot-level serialisers.
`timescale 1ns/1ps
`include "dapm_regs.vh"

// ----------------------------------------
// Playback buffer
// ----------------------------------------
module dapm_fifo #(
	parameter W = `DAPM_FIFO_W,
	parameter D = `DAPM_FIFO_D,
	parameter AW = `DAPM_FIFO_AW
) (
	input wire clk,
	input wire rst_b,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem [0:D-1];
	reg [AW:0] wr_reg;
	reg [AW:0] rd_reg;
	wire full = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
	wire empty = (wr_reg == rd_reg);
	wire push = in_valid & ~full;
	wire pop = out_ready & ~empty;

	assign in_ready = ~full;
	assign out_valid = ~empty;
	assign out_data = mem[rd_reg[AW-1:0]];

	always @(posedge clk) begin
		if (push) begin
			mem[wr_reg[AW-1:0]] <= in_data;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_reg <= {(AW+1){1'b0}};
			rd_reg <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= rd_reg + 1'b1;
			end
		end
	end
endmodule

// Function
// - Optical port one input carries lowest channels
// - Optical port one output sends lowest channels
// - Ports two to four input carry remaining channels
// - Ports two to four output send remaining channels
// - Port four selectable as SPDIF optical
// - SPDIF on port four drops its slots, channels 25-32 at single speed
// - Received AES channel status is ignored
// - AES status professional, two channel, 24-bit aux
// - Status rate field follows current rate
// - SPDIF status selectable consumer/pro, audio/non-audio
// - SPDIF status header built fresh
// - Output status always reports no emphasis
// - Same SPDIF stream on optical and coaxial
// - Base-rate word clock stays 32 to 48 kHz
// - Double is 64/88.2/96, quad 176.4/192
// - Higher speeds spread channel over 2/4 slots
// - No valid input forces internal master
module dapm_top (
	input wire clk,
	input wire rst_b,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire play_valid,
	output wire play_ready,
	input wire [4:0] play_chan,
	input wire [1:0] play_phase,
	input wire [23:0] play_sample,
	output wire opt_tx_valid,
	input wire opt_tx_ready,
	output reg [1:0] opt_tx_port,
	output reg [2:0] opt_tx_slot,
	output reg [23:0] opt_tx_sample,
	input wire opt_rx_valid,
	input wire [1:0] opt_rx_port,
	input wire [2:0] opt_rx_slot,
	input wire [23:0] opt_rx_sample,
	output reg rec_valid,
	output reg [4:0] rec_chan,
	output reg [1:0] rec_phase,
	output reg [23:0] rec_sample,
	input wire [7:0] cs_index,
	output reg aes_cs_bit,
	output reg spdif_cs_bit,
	output reg spdif_coax_en,
	output reg spdif_opt_en,
	input wire [5:0] src_lock,
	output reg clk_master,
	output reg [2:0] sync_src,
	output reg [1:0] speed,
	output reg [2:0] wclk_rate
);
	// ----------------------------------------
	// Decoding helpers
	// ----------------------------------------
	function [1:0] speed_of;
		input [2:0] rate;
		begin
			if (rate == `DAPM_R176 || rate == `DAPM_R192) begin
				speed_of = `DAPM_SPD_QUAD;
			end else if (rate >= `DAPM_R64) begin
				speed_of = `DAPM_SPD_DOUBLE;
			end else begin
				speed_of = `DAPM_SPD_SINGLE;
			end
		end
	endfunction
	// Status bit builder; no input status is ever consulted
	function cs_bit;
		input pro;
		input nonaudio;
		input [2:0] rate;
		input [7:0] idx;
		reg [39:0] blk;
		reg [1:0] pfs;
		reg [3:0] cfs;
		reg [3:0] efs;
		begin
			blk = 40'h00_0000_0000;
			pfs = 2'h0;
			cfs = 4'h0;
			efs = 4'h0;
			case (rate)
				`DAPM_R32: begin pfs = 2'h3; cfs = 4'h3; end
				`DAPM_R44: begin pfs = 2'h2; cfs = 4'h0; end
				`DAPM_R48: begin pfs = 2'h1; cfs = 4'h2; end
				`DAPM_R64: begin efs = 4'h1; cfs = 4'hd; end
				`DAPM_R88: begin efs = 4'ha; cfs = 4'h1; end
				`DAPM_R96: begin efs = 4'h2; cfs = 4'h5; end
				`DAPM_R176: begin efs = 4'hb; cfs = 4'hc; end
				default: begin efs = 4'h3; cfs = 4'he; end
			endcase
			if (nonaudio) begin
				blk[7:0] = `DAPM_CS_NONAUDIO;
			end
			if (pro) begin
				blk[7:0] = blk[7:0] | `DAPM_CS_PRO_B0 | `DAPM_CS_PRO_EMPH_NONE;
				blk[7:6] = pfs;
				blk[15:8] = `DAPM_CS_PRO_2CH;
				blk[23:16] = `DAPM_CS_PRO_AUX24;
				blk[38:35] = efs;
			end else begin
				blk[7:0] = blk[7:0] | `DAPM_CS_CON_COPY;
				blk[27:24] = cfs;
			end
			cs_bit = (idx < 8'h28) ? blk[idx[5:0]] : 1'b0;
		end
	endfunction

	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	reg [`DAPM_C_WIDTH-1:0] ctrl_reg;
	reg [31:0] drop_reg;
	wire wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
	wire [31:0] ctrl_full = {{(32-`DAPM_C_WIDTH){1'b0}}, ctrl_reg};
	wire [31:0] stat_word;
	wire [31:0] wmask;
	wire [31:0] ctrl_wr = (ctrl_full & ~wmask) | (s_axi_wdata & wmask);
	localparam [31:0] CTRL_RST = `DAPM_CTRL_RST;
	genvar gi;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign s_axi_arready = rd_go;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
			assign wmask[gi*8 +: 8] = {8{s_axi_wstrb[gi]}};
		end
	endgenerate

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl_reg <= CTRL_RST[`DAPM_C_WIDTH-1:0];
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= 2'h0;
				if (s_axi_awaddr[3:2] == `DAPM_CTRL_OFS >> 2) begin
					ctrl_reg <= ctrl_wr[`DAPM_C_WIDTH-1:0];
				end else if (s_axi_awaddr[3:2] != `DAPM_STAT_OFS >> 2 &&
					s_axi_awaddr[3:2] != `DAPM_DROP_OFS >> 2) begin
					s_axi_bresp <= 2'h2;
				end
			end
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else begin
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case (s_axi_araddr[3:2])
					`DAPM_CTRL_OFS >> 2: s_axi_rdata <= ctrl_full;
					`DAPM_STAT_OFS >> 2: s_axi_rdata <= stat_word;
					`DAPM_DROP_OFS >> 2: s_axi_rdata <= drop_reg;
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= 2'h2;
					end
				endcase
			end
		end
	end

	wire [2:0] rate = ctrl_reg[`DAPM_C_RATE_LSB +: 3];
	wire opt4_spdif = ctrl_reg[`DAPM_C_OPT4_SPDIF];
	wire [1:0] speed_now = speed_of(rate);

	// ----------------------------------------
	// Sync selection
	// ----------------------------------------
	reg [5:0] lock_meta_reg;
	reg [5:0] lock_reg;
	reg [2:0] src_next;
	integer k;
	always @* begin
		src_next = ctrl_reg[`DAPM_C_PREF_LSB +: 3];
		if (src_next >= `DAPM_NSRC || !lock_reg[src_next]) begin
			src_next = 3'h0;
			for (k = `DAPM_NSRC - 1; k >= 0; k = k - 1) begin
				if (lock_reg[k]) begin
					src_next = k[2:0];
				end
			end
		end
	end

	// ----------------------------------------
	// Word clock limit
	// ----------------------------------------
	reg [2:0] wclk_next;
	always @* begin
		wclk_next = rate;
		if (ctrl_reg[`DAPM_C_WC_BASE]) begin
			case (rate)
				`DAPM_R64: wclk_next = `DAPM_R32;
				`DAPM_R88: wclk_next = `DAPM_R44;
				`DAPM_R96: wclk_next = `DAPM_R48;
				`DAPM_R176: wclk_next = `DAPM_R44;
				`DAPM_R192: wclk_next = `DAPM_R48;
				default: wclk_next = rate;
			endcase
		end
	end
	assign stat_word = {17'h0_0000, wclk_rate, speed, sync_src, clk_master, lock_reg};
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lock_meta_reg <= 6'h00;
			lock_reg <= 6'h00;
			clk_master <= 1'b1;
			sync_src <= 3'h0;
			speed <= `DAPM_SPD_SINGLE;
			wclk_rate <= `DAPM_R32;
			aes_cs_bit <= 1'b0;
			spdif_cs_bit <= 1'b0;
			spdif_coax_en <= 1'b0;
			spdif_opt_en <= 1'b0;
		end else begin
			lock_meta_reg <= src_lock;
			lock_reg <= lock_meta_reg;
			clk_master <= ctrl_reg[`DAPM_C_MASTER] | ~(|lock_reg);
			sync_src <= src_next;
			speed <= speed_now;
			wclk_rate <= wclk_next;
			// AES output is always professional audio
			aes_cs_bit <= cs_bit(1'b1, 1'b0, rate, cs_index);
			spdif_cs_bit <= cs_bit(ctrl_reg[`DAPM_C_PRO],
				ctrl_reg[`DAPM_C_NONAUDIO], rate, cs_index);
			spdif_coax_en <= 1'b1;
			spdif_opt_en <= opt4_spdif;
		end
	end

	// ----------------------------------------
	// Playback path
	// ----------------------------------------
	wire f_valid;
	wire [`DAPM_FIFO_W-1:0] f_data;
	wire [4:0] f_chan = f_data[30:26];
	wire [1:0] f_phase = f_data[25:24];
	wire [1:0] pmask = (speed == `DAPM_SPD_QUAD) ? 2'h3 :
		(speed == `DAPM_SPD_DOUBLE) ? 2'h1 : 2'h0;
	// Channel index shifted by speed plus phase masked by pmask gives the global slot
	wire [6:0] tx_glob = ({2'h0, f_chan} << speed) + {5'h00, f_phase & pmask};
	wire tx_drop = tx_glob[6:5] != 2'h0 ||
		(opt4_spdif && tx_glob[4:3] == `DAPM_NPORT - 3'h1);
	reg tx_full_reg;
	wire f_take = f_valid & (~tx_full_reg | opt_tx_ready);
	assign opt_tx_valid = tx_full_reg;
	// Drain when the output slot is empty or the serialiser takes it, so a stalled link fills the buffer behind one held item
	dapm_fifo #(
		.W(`DAPM_FIFO_W),
		.D(`DAPM_FIFO_D),
		.AW(`DAPM_FIFO_AW)
	) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(play_valid),
		.in_ready(play_ready),
		.in_data({play_chan, play_phase, play_sample}),
		.out_valid(f_valid),
		.out_ready(f_take),
		.out_data(f_data)
	);
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_full_reg <= 1'b0;
			opt_tx_port <= 2'h0;
			opt_tx_slot <= 3'h0;
			opt_tx_sample <= 24'h00_0000;
			drop_reg <= 32'h0000_0000;
		end else begin
			if (opt_tx_ready) begin
				tx_full_reg <= 1'b0;
			end
			if (f_take) begin
				if (tx_drop) begin
					drop_reg <= drop_reg + 32'h0000_0001;
				end else begin
					tx_full_reg <= 1'b1;
					opt_tx_port <= tx_glob[4:3];
					opt_tx_slot <= tx_glob[2:0];
					opt_tx_sample <= f_data[23:0];
				end
			end
		end
	end

	// ----------------------------------------
	// Record path
	// ----------------------------------------
	wire [4:0] rx_glob = {opt_rx_port, opt_rx_slot};
	wire rx_skip = opt4_spdif && opt_rx_port == `DAPM_NPORT - 3'h1;
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rec_valid <= 1'b0;
			rec_chan <= 5'h00;
			rec_phase <= 2'h0;
			rec_sample <= 24'h00_0000;
		end else begin
			rec_valid <= opt_rx_valid & ~rx_skip;
			if (opt_rx_valid && !rx_skip) begin
				rec_chan <= rx_glob >> speed;
				rec_phase <= rx_glob[1:0] & pmask;
				rec_sample <= opt_rx_sample;
			end
		end
	end
endmodule

/* verif/dapm_top_sva.sv */
// Checker for the port mapper top level.
// Assumes binding to dapm_top and sight of its ports only.
`timescale 1ns/1ps
module dapm_chk (
	input wire clk,
	input wire rst_b,
	input wire [7:0] cs_index,
	input wire aes_cs_bit,
	input wire spdif_cs_bit,
	input wire opt_rx_valid,
	input wire [1:0] opt_rx_port,
	input wire [2:0] opt_rx_slot,
	input wire [23:0] opt_rx_sample,
	input wire rec_valid,
	input wire [4:0] rec_chan,
	input wire [1:0] rec_phase,
	input wire [23:0] rec_sample,
	input wire opt_tx_valid,
	input wire opt_tx_ready,
	input wire [1:0] opt_tx_port,
	input wire [23:0] opt_tx_sample,
	input wire spdif_opt_en,
	input wire spdif_coax_en,
	input wire [1:0] speed,
	input wire [5:0] src_lock,
	input wire clk_master
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	sequence s_no_lock;
		(src_lock == 6'h00) [*4];
	endsequence
	sequence s_rx_kept;
		opt_rx_valid && !(opt_rx_port == 2'h3 && spdif_opt_en);
	endsequence
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	a_cs_pro: assert property (cs_index == 8'h00 |=> aes_cs_bit)
		else $error("aes status not professional");
	a_cs_audio: assert property (cs_index == 8'h01 |=> !aes_cs_bit)
		else $error("aes status not audio");
	a_cs_emph: assert property (cs_index >= 8'h02 && cs_index <= 8'h04
		|=> aes_cs_bit == ($past(cs_index) == 8'h02)) else $error("aes emphasis set");
	a_spdif_emph: assert property (cs_index == 8'h03 || cs_index == 8'h04
		|=> !spdif_cs_bit) else $error("spdif emphasis set");
	a_rec_pulse: assert property (s_rx_kept |=> rec_valid)
		else $error("received slot not recorded");
	a_rec_map: assert property (rec_valid |-> (rec_chan << speed) + rec_phase ==
		{$past(opt_rx_port), $past(opt_rx_slot)} && rec_sample == $past(opt_rx_sample))
		else $error("record slot mapping wrong");
	a_tx_hold: assert property (opt_tx_valid && !opt_tx_ready |=> opt_tx_valid
		&& $stable(opt_tx_sample) && $stable(opt_tx_port)) else $error("tx item dropped");
	a_port4_off: assert property (opt_tx_valid && spdif_opt_en |-> opt_tx_port != 2'h3)
		else $error("port four sent in spdif mode");
	a_auto_master: assert property (s_no_lock |=> clk_master)
		else $error("no master without lock");
	a_coax_on: assert property ($past(rst_b) |-> spdif_coax_en)
		else $error("coaxial output off");
endmodule
bind dapm_top dapm_chk u_chk (.clk, .rst_b, .cs_index, .aes_cs_bit, .spdif_cs_bit,
	.opt_rx_valid, .opt_rx_port, .opt_rx_slot, .opt_rx_sample, .rec_valid, .rec_chan,
	.rec_phase, .rec_sample, .opt_tx_valid, .opt_tx_ready, .opt_tx_port, .opt_tx_sample,
	.spdif_opt_en, .spdif_coax_en, .speed, .src_lock, .clk_master);

/* verif/dapm_optic_peer.sv */
// Model of the optical serialisers and the devices beyond them.
// Assumes the bench drives stall and calls send.
`timescale 1ns/1ps
module dapm_optic_peer (
	input wire clk,
	input wire stall,
	input wire opt_tx_valid,
	output wire opt_tx_ready,
	input wire [1:0] opt_tx_port,
	input wire [2:0] opt_tx_slot,
	input wire [23:0] opt_tx_sample,
	output logic opt_rx_valid,
	output logic [1:0] opt_rx_port,
	output logic [2:0] opt_rx_slot,
	output logic [23:0] opt_rx_sample
);
	logic [28:0] got[$];
	assign opt_tx_ready = !stall;
	initial begin
		opt_rx_valid = 1'b0;
		opt_rx_port = 2'h0;
		opt_rx_slot = 3'h0;
		opt_rx_sample = 24'h0;
	end
	always @(posedge clk) begin
		if (opt_tx_valid && opt_tx_ready) got.push_back({opt_tx_port, opt_tx_slot, opt_tx_sample});
	end
	// Released data is inverted so a stale value never passes
	task send(input logic [1:0] p, input logic [2:0] sl, input logic [23:0] x);
		begin
			@(posedge clk);
			opt_rx_valid <= 1'b1;
			opt_rx_port <= p;
			opt_rx_slot <= sl;
			opt_rx_sample <= x;
			@(posedge clk);
			opt_rx_valid <= 1'b0;
			opt_rx_sample <= ~x;
		end
	endtask
endmodule

/* verif/testbench.sv */
// Self-checking bench for the port mapper.
// Assumes dapm_top, its checker and the optical peer model.
`timescale 1ns/1ps
module testbench;
	logic clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, d0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, play_phase, rec_phase, opt_tx_port, opt_rx_port, speed;
	logic play_valid, play_ready, opt_tx_valid, opt_tx_ready, opt_rx_valid, rec_valid, stall;
	logic [4:0] play_chan, rec_chan, g;
	logic [23:0] play_sample, opt_tx_sample, opt_rx_sample, rec_sample, v;
	logic [2:0] opt_tx_slot, opt_rx_slot, sync_src, wclk_rate;
	logic [7:0] cs_index;
	logic aes_cs_bit, spdif_cs_bit, spdif_coax_en, spdif_opt_en, clk_master;
	logic [5:0] src_lock;
	int fail_count, samples_checked, i, j, n, s;
	int wc[8] = '{0, 1, 2, 0, 1, 2, 1, 2};
	int rt[5] = '{2, 2, 5, 7, 7};
	int ch[5] = '{0, 9, 5, 3, 1};
	int ph[5] = '{0, 0, 1, 3, 2};
	dapm_top uut (.*);
	dapm_optic_peer peer (.*);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		begin
			samples_checked++;
			if (seen !== exp) begin
				fail_count++;
				$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] x);
		begin
			@(posedge clk);
			s_axi_awaddr <= a;
			s_axi_wdata <= x;
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			do begin
				@(posedge clk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
			end while (!s_axi_bvalid);
			s_axi_bready <= 1'b0;
		end
	endtask
	task rd(input logic [3:0] a, output logic [31:0] x, output logic [1:0] rs);
		begin
			@(posedge clk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			do begin
				@(posedge clk);
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
			end while (!s_axi_rvalid);
			x = s_axi_rdata;
			rs = s_axi_rresp;
			s_axi_rready <= 1'b0;
		end
	endtask
	task push(input logic [4:0] c, input logic [1:0] p, input logic [23:0] x);
		begin
			@(posedge clk);
			play_valid <= 1'b1;
			play_chan <= c;
			play_phase <= p;
			play_sample <= x;
			do @(posedge clk); while (!play_ready);
			play_valid <= 1'b0;
		end
	endtask
	task expect_tx(input logic [1:0] p, input logic [2:0] sl, input logic [23:0] x);
		int k;
		begin
			k = 0;
			while (peer.got.size() == 0 && k < 40) begin
				@(posedge clk);
				k++;
			end
			chk(peer.got.size() ? peer.got.pop_front() : 29'h0, {p, sl, x});
		end
	endtask
	task results;
		begin
			$display("Checks %0d, mismatches %0d", samples_checked, fail_count);
			if (fail_count == 0 && samples_checked > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	initial begin
		#2000000;
		fail_count++;
		results;
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		{rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, play_valid, play_chan, play_phase} = 0;
		{play_sample, cs_index, src_lock, stall} = 0;
		s_axi_wstrb = 4'hf;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		rd(4'h0, d, r);
		chk(d, 32'h2);
		rd(4'h4, d, r);
		chk(d & 32'h0c40, 32'h40);
		rd(4'hc, d, r);
		chk({d, r}, 34'h2);
		wr(4'hc, 32'h0000_07ff);
		chk(s_axi_bresp, 2'h2);
		rd(4'h0, d, r);
		chk(d, 32'h2);
		for (i = 0; i < 8; i++) begin
			wr(4'h0, 32'h400 | i);
			rd(4'h4, d, r);
			chk(d[11:10], i < 3 ? 0 : i < 6 ? 1 : 2);
			chk(d[14:12], wc[i]);
			chk(wclk_rate, wc[i]);
			chk(speed, i < 3 ? 0 : i < 6 ? 1 : 2);
		end
		// Stalled peer makes every item wait in the output slot
		for (i = 0; i < 5; i++) begin
			wr(4'h0, rt[i]);
			s = rt[i] < 3 ? 0 : rt[i] < 6 ? 1 : 2;
			g = (ch[i] << s) + (ph[i] & ((1 << s) - 1));
			stall <= 1'b1;
			push(ch[i], ph[i], 24'h5a0000 + i);
			repeat (5) @(posedge clk);
			stall <= 1'b0;
			expect_tx(g[4:3], g[2:0], 24'h5a0000 + i);
			v = 24'ha50000 + i;
			peer.send(g[4:3], g[2:0], v);
			#1;
			chk({rec_valid, rec_chan, rec_phase, rec_sample}, {1'b1, 5'(ch[i]), 2'(ph[i]), v});
		end
		rd(4'h8, d0, r);
		push(5'd8, 2'h0, 24'h1);
		rd(4'h8, d, r);
		chk(d, d0 + 1);
		wr(4'h0, 32'h82);
		push(5'd25, 2'h0, 24'h2);
		rd(4'h8, d, r);
		chk(d, d0 + 2);
		chk({peer.got.size() == 0, spdif_opt_en, spdif_coax_en}, 3'h7);
		peer.send(2'h3, 3'h0, 24'h3);
		#1;
		chk(rec_valid, 0);
		for (j = 0; j < 2; j++) begin
			wr(4'h0, j ? 32'h2 : 32'h302);
			for (i = 0; i < 5; i++) begin
				@(posedge clk);
				cs_index <= i;
				@(posedge clk);
				#1;
				chk({aes_cs_bit, spdif_cs_bit},
					{1'(5'b00101 >> i), 1'((j ? 5'b00100 : 5'b00111) >> i)});
			end
		end
		@(posedge clk) src_lock <= 6'h04;
		wr(4'h0, 32'h22);
		rd(4'h4, d, r);
		chk(d[9:6], 4'h4);
		chk({sync_src, clk_master}, 4'h4);
		src_lock <= 6'h00;
		repeat (4) @(posedge clk);
		rd(4'h4, d, r);
		chk(d[6], 1);
		chk(clk_master, 1);
		wr(4'h0, 32'h2);
		stall <= 1'b1;
		play_chan <= 5'h01;
		play_phase <= 2'h0;
		play_sample <= 24'h0;
		play_valid <= 1'b1;
		n = 0;
		repeat (20) begin
			@(posedge clk);
			if (play_ready) begin
				n++;
				play_sample <= n;
			end
		end
		play_valid <= 1'b0;
		chk(n, 17);
		stall <= 1'b0;
		for (i = 0; i < 17; i++) expect_tx(2'h0, 3'h1, i);
		results;
	end
endmodule
